/* File: logic/spbcfg_pkg.sv */
// Shared constants, types and helpers of the stream port B register bank.
package spbcfg_pkg;

  localparam int ADR_W = 8;
  localparam int DAT_W = 32;
  localparam int SEL_W = 4;
  localparam int BUF_IDX_W = 3;
  localparam int BUF_CNT = 8;
  localparam int BLK_W = 12;

  localparam logic [ADR_W-1:0] OFS_CFG0 = 8'hc0;
  localparam logic [ADR_W-1:0] OFS_CFG1 = 8'hc4;
  localparam logic [ADR_W-1:0] OFS_STAT = 8'hc8;
  localparam logic [ADR_W-1:0] OFS_MASK = 8'hcc;
  localparam logic [ADR_W-1:0] OFS_CTRL = 8'hf0;

  localparam int CFG0_MAP_LSB = 0;
  localparam int CFG0_SERIAL_BIT = 8;
  localparam int CFG0_ORDER_BIT = 9;
  localparam int CFG0_SYNC_LSB = 13;
  localparam int CFG1_END_LSB = 0;
  localparam int CFG1_TX_BIT = 12;
  localparam int CFG1_RX_BIT = 14;
  localparam int ST_OVF_BIT = 0;
  localparam int ST_INS_BIT = 8;
  localparam int CTRL_INS_BIT = 0;

  localparam logic [BUF_CNT-1:0] MAP_RST = 8'h0c;
  localparam logic [DAT_W-1:0] STAT_IMPL = 32'h0000_0101;
  localparam logic [BLK_W-1:0] BLK_ONE = 12'h001;

  typedef enum logic [1:0] {
    SYNC_A = 2'b00,
    SYNC_B = 2'b01,
    SYNC_RSV = 2'b10,
    SYNC_C = 2'b11
  } spbcfg_sync_e;

  typedef struct packed {
    spbcfg_sync_e sync;
    logic order;
    logic serial;
    logic [BUF_CNT-1:0] map;
  } spbcfg_cfg0_s;

  typedef struct packed {
    logic rx_multi;
    logic tx_multi;
    logic [BLK_W-1:0] blk_end;
  } spbcfg_cfg1_s;

  // Lowest buffer number whose map bit is set; zero when none is mapped.
  function automatic logic [BUF_IDX_W-1:0] first_set(
      input logic [BUF_CNT-1:0] map);
    logic [BUF_IDX_W-1:0] idx;
    idx = '0;
    for (int i = BUF_CNT - 1; i >= 0; i--) begin
      if (map[i]) begin
        idx = BUF_IDX_W'(i);
      end
    end
    return idx;
  endfunction : first_set

  // Merges write data into an old word under the Wishbone byte selects.
  function automatic logic [DAT_W-1:0] wmask(input logic [DAT_W-1:0] old,
      input logic [DAT_W-1:0] wr, input logic [SEL_W-1:0] sel);
    logic [DAT_W-1:0] res;
    res = old;
    for (int b = 0; b < SEL_W; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = wr[b*8 +: 8];
      end
    end
    return res;
  endfunction : wmask

endpackage : spbcfg_pkg

/* File: logic/spbcfg_sync.sv */
// Two-stage synchroniser for a group of asynchronous pin levels.
`timescale 1ns/1ps
module spbcfg_sync #(
  parameter int W = 1
) (
  input wire logic clk, // Device clock.
  input wire logic nrst, // Asynchronous reset, active low.
  input wire logic [W-1:0] d, // Asynchronous levels.
  output logic [W-1:0] q // Synchronised levels.
);
  logic [W-1:0] s1_reg;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1_reg <= '0;
      q <= '0;
    end else begin
      s1_reg <= d;
      q <= s1_reg;
    end
  end
endmodule : spbcfg_sync

/* File: logic/spbcfg_deser.sv */
// Byte assembly for the data port in serial or byte-wide mode.
`timescale 1ns/1ps
module spbcfg_deser #(
  parameter int BITS = 8
) (
  input wire logic clk, // Device clock.
  input wire logic nrst, // Asynchronous reset, active low.
  input wire logic in_valid, // One transfer at the port.
  input wire logic [BITS-1:0] par_data, // Port data lines.
  input wire logic serial, // Serial mode selected.
  input wire logic lsb_first, // Serial bit order.
  output logic out_valid, // Byte complete, one-cycle pulse.
  output logic [BITS-1:0] out_data // Assembled byte.
);
  localparam int CW = $clog2(BITS);
  localparam logic [CW-1:0] LAST = CW'(BITS - 1);
  localparam logic [CW-1:0] ONE = CW'(1);

  logic [BITS-1:0] sh_reg;
  logic [CW-1:0] cnt_reg;
  wire bit_in = par_data[0];
  wire [BITS-1:0] sh_next = lsb_first ? {bit_in, sh_reg[BITS-1:1]}
                                      : {sh_reg[BITS-2:0], bit_in};

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sh_reg <= '0;
      cnt_reg <= '0;
      out_valid <= 1'b0;
      out_data <= '0;
    end else begin
      out_valid <= 1'b0;
      if (!serial) begin
        cnt_reg <= '0;
        if (in_valid) begin
          out_valid <= 1'b1;
          out_data <= par_data;
        end
      end else if (in_valid) begin
        sh_reg <= sh_next;
        cnt_reg <= cnt_reg + ONE;
        if (cnt_reg == LAST) begin
          out_valid <= 1'b1;
          out_data <= sh_next;
        end
      end
    end
  end

  property p_msb_first;
    @(posedge clk) disable iff (!nrst)
    serial && !lsb_first && in_valid && cnt_reg == LAST |=>
      out_valid && out_data[0] == $past(par_data[0]) &&
      out_data[BITS-1:1] == $past(sh_reg[BITS-2:0]);
  endproperty
  a_msb_first: assert property (p_msb_first)
    else $error("serial byte with order 0 assembled wrongly");

  property p_lsb_first;
    @(posedge clk) disable iff (!nrst)
    serial && lsb_first && in_valid && cnt_reg == LAST |=>
      out_valid && out_data[BITS-1] == $past(par_data[0]);
  endproperty
  a_lsb_first: assert property (p_lsb_first)
    else $error("serial byte with order 1 assembled wrongly");

  property p_parallel;
    @(posedge clk) disable iff (!nrst)
    !serial && in_valid |=> out_valid && out_data == $past(par_data);
  endproperty
  a_parallel: assert property (p_parallel)
    else $error("byte-wide transfer altered by bit order");
endmodule : spbcfg_deser

/* File: logic/spbcfg_top.sv */
// Stream port B configuration, buffer steering and interrupt bank.
//
// Behaviour
// - Serial bit order picks MSB- or LSB-first assembly.
// - Bit order is ignored in byte-wide mode.
// - Serial mode takes data from line 0 only.
// - Each buffer map bit maps one buffer.
// - Reset maps buffers 2 and 3 only.
// - Receive multi-stream uses select bus, else map.
// - Transmit multi-stream uses select bus, else map.
// - Block-size end sets block length in modes A/B.
// - Sync mode C ignores block-size end.
// - Insertion done sets its status flag.
// - Insertion done disables insertion until re-enabled.
// - Lost port data sets transmit-overflow flag.
// - Reserved bits ignore writes, read zero.
// - Enabled status bits raise the port interrupt.
//
// The Wishbone register port was left to the implementer.
`timescale 1ns/1ps
module spbcfg_top (
  input wire logic SYS_CLK, // Device clock, 250 MHz.
  input wire logic NRST, // Asynchronous reset, active low.
  input wire logic WB_CYC_I, // Wishbone cycle.
  input wire logic WB_STB_I, // Wishbone strobe.
  input wire logic WB_WE_I, // Wishbone write enable.
  input wire logic [spbcfg_pkg::ADR_W-1:0] WB_ADR_I, // Byte address.
  input wire logic [spbcfg_pkg::SEL_W-1:0] WB_SEL_I, // Byte selects.
  input wire logic [spbcfg_pkg::DAT_W-1:0] WB_DAT_I, // Write data.
  output logic [spbcfg_pkg::DAT_W-1:0] WB_DAT_O, // Read data.
  output logic WB_ACK_O, // Wishbone acknowledge.
  input wire logic [7:0] STRM_D, // Port data lines.
  input wire logic STRM_STB, // Port transfer strobe.
  input wire logic [spbcfg_pkg::BUF_IDX_W-1:0] STRM_BSEL, // Buffer select.
  input wire logic BUF_FULL, // Target buffer cannot take a byte.
  input wire logic INSERT_DONE, // Packet insertion finished, pulse.
  output logic [7:0] BUF_WR_DATA, // Byte to the stream buffer.
  output logic BUF_WR_VALID, // Byte write pulse.
  output logic [spbcfg_pkg::BUF_IDX_W-1:0] BUF_WR_IDX, // Write target.
  output logic [spbcfg_pkg::BUF_IDX_W-1:0] BUF_RD_IDX, // Read source.
  output logic [spbcfg_pkg::BUF_CNT-1:0] BUF_MAP, // Mapped buffers.
  output logic PORT_SERIAL, // Port runs serially.
  output logic BLOCK_END, // Last byte of a block, pulse.
  output logic INSERT_EN, // Packet insertion enabled.
  output logic IRQ // Port interrupt, level.
);
  import spbcfg_pkg::*;

  // Pin inputs pass two flip-flops before use.
  logic [11:0] pin_s;
  spbcfg_sync #(
    .W(12)
  ) u_sync (
    .clk(SYS_CLK),
    .nrst(NRST),
    .d({STRM_BSEL, STRM_STB, STRM_D}),
    .q(pin_s)
  );
  wire [7:0] d_s = pin_s[7:0];
  wire stb_s = pin_s[8];
  wire [BUF_IDX_W-1:0] bsel_s = pin_s[11:9];

  spbcfg_cfg0_s cfg0_reg;
  spbcfg_cfg0_s cfg0_next;
  spbcfg_cfg1_s cfg1_reg;
  spbcfg_cfg1_s cfg1_next;
  logic [DAT_W-1:0] stat_reg;
  logic [DAT_W-1:0] stat_next;
  logic [DAT_W-1:0] mask_reg;
  logic [DAT_W-1:0] mask_next;
  logic ins_en_reg;
  logic ins_en_next;
  logic stb_d_reg;
  logic [BLK_W-1:0] blk_cnt_reg;
  logic [BLK_W-1:0] blk_cnt_next;

  wire stb_rise = stb_s & ~stb_d_reg;
  logic byte_valid;
  logic [7:0] byte_data;

  spbcfg_deser #(
    .BITS(8)
  ) u_deser (
    .clk(SYS_CLK),
    .nrst(NRST),
    .in_valid(stb_rise),
    .par_data(d_s),
    .serial(cfg0_reg.serial),
    .lsb_first(cfg0_reg.order),
    .out_valid(byte_valid),
    .out_data(byte_data)
  );

  // Bus decode: one request is taken per cycle while ack is low.
  wire wb_go = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
  wire wr_go = wb_go & WB_WE_I;
  wire rd_go = wb_go & ~WB_WE_I;
  wire hit_cfg0 = WB_ADR_I == OFS_CFG0;
  wire hit_cfg1 = WB_ADR_I == OFS_CFG1;
  wire hit_stat = WB_ADR_I == OFS_STAT;
  wire hit_mask = WB_ADR_I == OFS_MASK;
  wire hit_ctrl = WB_ADR_I == OFS_CTRL;

  // Read views; unimplemented bits stay zero.
  wire [DAT_W-1:0] rd_cfg0 = (DAT_W'(cfg0_reg.map) << CFG0_MAP_LSB) |
      (DAT_W'(cfg0_reg.serial) << CFG0_SERIAL_BIT) |
      (DAT_W'(cfg0_reg.order) << CFG0_ORDER_BIT) |
      (DAT_W'(cfg0_reg.sync) << CFG0_SYNC_LSB);
  wire [DAT_W-1:0] rd_cfg1 = (DAT_W'(cfg1_reg.blk_end) << CFG1_END_LSB) |
      (DAT_W'(cfg1_reg.tx_multi) << CFG1_TX_BIT) |
      (DAT_W'(cfg1_reg.rx_multi) << CFG1_RX_BIT);
  wire [DAT_W-1:0] rd_ctrl = DAT_W'(ins_en_reg) << CTRL_INS_BIT;
  wire [DAT_W-1:0] rd_data = hit_cfg0 ? rd_cfg0 :
                             hit_cfg1 ? rd_cfg1 :
                             hit_stat ? stat_reg :
                             hit_mask ? mask_reg :
                             hit_ctrl ? rd_ctrl : '0;

  // Writes merge under the byte selects; only stored fields are kept.
  wire [DAT_W-1:0] w_cfg0 = wmask(rd_cfg0, WB_DAT_I, WB_SEL_I);
  wire [DAT_W-1:0] w_cfg1 = wmask(rd_cfg1, WB_DAT_I, WB_SEL_I);
  wire [DAT_W-1:0] w_mask = wmask(mask_reg, WB_DAT_I, WB_SEL_I);
  wire [DAT_W-1:0] w_ctrl = wmask(rd_ctrl, WB_DAT_I, WB_SEL_I);

  always_comb begin
    cfg0_next = cfg0_reg;
    if (wr_go && hit_cfg0) begin
      cfg0_next.map = w_cfg0[CFG0_MAP_LSB +: BUF_CNT];
      cfg0_next.serial = w_cfg0[CFG0_SERIAL_BIT];
      cfg0_next.order = w_cfg0[CFG0_ORDER_BIT];
      cfg0_next.sync = spbcfg_sync_e'(w_cfg0[CFG0_SYNC_LSB +: 2]);
    end
  end

  always_comb begin
    cfg1_next = cfg1_reg;
    if (wr_go && hit_cfg1) begin
      cfg1_next.blk_end = w_cfg1[CFG1_END_LSB +: BLK_W];
      cfg1_next.tx_multi = w_cfg1[CFG1_TX_BIT];
      cfg1_next.rx_multi = w_cfg1[CFG1_RX_BIT];
    end
  end

  // Buffer steering from the map or from the select bus.
  wire [BUF_IDX_W-1:0] map_idx = first_set(cfg0_reg.map);
  wire [BUF_IDX_W-1:0] tx_idx = cfg1_reg.tx_multi ? bsel_s
                                                  : map_idx;
  wire [BUF_IDX_W-1:0] rd_idx = cfg1_reg.rx_multi ? bsel_s
                                                  : map_idx;

  // A byte that meets a full buffer is dropped and flagged.
  wire ovf_ev = byte_valid & BUF_FULL;
  wire wr_ok = byte_valid & ~BUF_FULL;

  // Block framing counts every presented byte in sync modes A and B.
  wire framed = (cfg0_reg.sync == SYNC_A) ||
                (cfg0_reg.sync == SYNC_B);
  wire [BLK_W-1:0] blk_inc = blk_cnt_reg + BLK_ONE;
  wire blk_hit = framed && byte_valid && (cfg1_reg.blk_end != '0) &&
                 (blk_inc == cfg1_reg.blk_end);
  assign blk_cnt_next = !framed ? '0 :
                        blk_hit ? '0 :
                        byte_valid ? blk_inc : blk_cnt_reg;

  // Status: a read clears, but an event in the same cycle survives.
  wire [DAT_W-1:0] ev = (DAT_W'(ovf_ev) << ST_OVF_BIT) |
                        (DAT_W'(INSERT_DONE) << ST_INS_BIT);
  wire stat_rd = rd_go & hit_stat;
  assign stat_next = ((stat_rd ? '0 : stat_reg) | ev) & STAT_IMPL;
  assign mask_next = (wr_go && hit_mask) ? (w_mask & STAT_IMPL)
                                         : mask_reg;
  wire irq_next = |(stat_reg & mask_reg);

  // Hardware disable on completion outranks a software enable.
  assign ins_en_next = INSERT_DONE ? 1'b0 :
                       (wr_go && hit_ctrl) ? w_ctrl[CTRL_INS_BIT] :
                       ins_en_reg;

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      cfg0_reg <= '{sync: SYNC_A, order: 1'b0, serial: 1'b0,
                    map: MAP_RST};
      cfg1_reg <= '0;
      stat_reg <= '0;
      mask_reg <= '0;
      ins_en_reg <= 1'b0;
    end else begin
      cfg0_reg <= cfg0_next;
      cfg1_reg <= cfg1_next;
      stat_reg <= stat_next;
      mask_reg <= mask_next;
      ins_en_reg <= ins_en_next;
    end
  end

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= '0;
    end else begin
      WB_ACK_O <= wb_go;
      WB_DAT_O <= rd_go ? rd_data : '0;
    end
  end

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      stb_d_reg <= 1'b0;
      blk_cnt_reg <= '0;
      BUF_WR_DATA <= '0;
      BUF_WR_VALID <= 1'b0;
      BUF_WR_IDX <= '0;
      BUF_RD_IDX <= '0;
    end else begin
      stb_d_reg <= stb_s;
      blk_cnt_reg <= blk_cnt_next;
      BUF_WR_VALID <= wr_ok;
      if (byte_valid) begin
        BUF_WR_DATA <= byte_data;
        BUF_WR_IDX <= tx_idx;
      end
      BUF_RD_IDX <= rd_idx;
    end
  end

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      BUF_MAP <= MAP_RST;
      PORT_SERIAL <= 1'b0;
      BLOCK_END <= 1'b0;
      INSERT_EN <= 1'b0;
      IRQ <= 1'b0;
    end else begin
      BUF_MAP <= cfg0_next.map;
      PORT_SERIAL <= cfg0_next.serial;
      BLOCK_END <= blk_hit;
      INSERT_EN <= ins_en_next;
      IRQ <= irq_next;
    end
  end

  sequence s_stat_read;
    rd_go && hit_stat;
  endsequence

  property p_map_reset;
    @(posedge SYS_CLK) $rose(NRST) |-> cfg0_reg.map == MAP_RST;
  endproperty
  a_map_reset: assert property (p_map_reset)
    else $error("buffer map reset value wrong");

  property p_rx_sel;
    @(posedge SYS_CLK) disable iff (!NRST)
    1'b1 |=> BUF_RD_IDX == ($past(cfg1_reg.rx_multi) ? $past(bsel_s)
                                                     : $past(map_idx));
  endproperty
  a_rx_sel: assert property (p_rx_sel)
    else $error("read buffer index not steered correctly");

  property p_tx_sel;
    @(posedge SYS_CLK) disable iff (!NRST)
    byte_valid && cfg1_reg.tx_multi |=> BUF_WR_IDX == $past(bsel_s);
  endproperty
  a_tx_sel: assert property (p_tx_sel)
    else $error("write buffer index ignores select bus");

  property p_blk_mode_c;
    @(posedge SYS_CLK) disable iff (!NRST)
    cfg0_reg.sync == SYNC_C |=> !BLOCK_END && blk_cnt_reg == '0;
  endproperty
  a_blk_mode_c: assert property (p_blk_mode_c)
    else $error("block framing active in sync mode C");

  property p_blk_end;
    @(posedge SYS_CLK) disable iff (!NRST)
    framed && byte_valid && cfg1_reg.blk_end != '0 &&
      blk_inc == cfg1_reg.blk_end |=> BLOCK_END && blk_cnt_reg == '0;
  endproperty
  a_blk_end: assert property (p_blk_end)
    else $error("block end not flagged at programmed size");

  property p_ins_done;
    @(posedge SYS_CLK) disable iff (!NRST)
    INSERT_DONE |=> stat_reg[ST_INS_BIT] && !INSERT_EN && !ins_en_reg;
  endproperty
  a_ins_done: assert property (p_ins_done)
    else $error("insertion done did not flag and disable");

  property p_ovf;
    @(posedge SYS_CLK) disable iff (!NRST)
    byte_valid && BUF_FULL |=> stat_reg[ST_OVF_BIT] && !BUF_WR_VALID;
  endproperty
  a_ovf: assert property (p_ovf)
    else $error("overflow not flagged or byte not dropped");

  property p_read_clear;
    @(posedge SYS_CLK) disable iff (!NRST)
    s_stat_read ##0 (!INSERT_DONE && !ovf_ev) |=> stat_reg == '0;
  endproperty
  a_read_clear: assert property (p_read_clear)
    else $error("status read did not clear flags");

  property p_irq;
    @(posedge SYS_CLK) disable iff (!NRST)
    1'b1 |=> IRQ == |($past(stat_reg) & $past(mask_reg));
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt output disagrees with status and mask");

  property p_rsvd;
    @(posedge SYS_CLK) disable iff (!NRST)
    rd_go && hit_cfg1 |=> WB_ACK_O && WB_DAT_O[31:15] == '0 &&
      WB_DAT_O[13] == 1'b0;
  endproperty
  a_rsvd: assert property (p_rsvd)
    else $error("reserved bits read nonzero");
endmodule : spbcfg_top

/* File: bench/spbcfg_app.sv */
// Model of the application logic that drives the port B pins.
`timescale 1ns/1ps
module spbcfg_app (
  input wire logic clk, // Device clock.
  output logic [7:0] d, // Port data lines.
  output logic stb, // Port transfer strobe.
  output logic [2:0] bsel // Buffer number, binary.
);
  initial begin
    d = 8'h00;
    stb = 1'b0;
    bsel = 3'h0;
  end

  // One transfer; data is inverted once its hold time has run out.
  task automatic xfer(input logic [7:0] v, input logic [2:0] b);
    @(posedge clk);
    d <= v;
    bsel <= b;
    repeat (2) @(posedge clk);
    stb <= 1'b1;
    repeat (4) @(posedge clk);
    stb <= 1'b0;
    d <= ~v;
    repeat (3) @(posedge clk);
  endtask : xfer

  // Serial byte, first bit from the MSB of seq; idle lines sit high.
  task automatic send_serial(input logic [7:0] seq);
    for (int i = 7; i >= 0; i--) begin
      xfer({7'h7f, seq[i]}, 3'h0);
    end
  endtask : send_serial
endmodule : spbcfg_app

/* File: bench/tb.sv */
// Self-checking bench for the stream port B register bank.
`timescale 1ns/1ps
module tb;
  import spbcfg_pkg::*;
  typedef struct packed {
    logic [ADR_W-1:0] adr;
    logic [SEL_W-1:0] sel;
    logic [DAT_W-1:0] wr;
    logic [DAT_W-1:0] exp;
  } spbcfg_row_s;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic [ADR_W-1:0] adr = '0;
  logic [SEL_W-1:0] sel = '0;
  logic [DAT_W-1:0] wdat = '0;
  logic [DAT_W-1:0] rdat;
  logic ack;
  logic [7:0] pd;
  logic pstb;
  logic [2:0] pbsel;
  logic full = 1'b0;
  logic ins = 1'b0;
  logic [7:0] wr_data;
  logic wr_valid;
  logic [2:0] wr_idx;
  logic [2:0] rd_idx;
  logic [7:0] map;
  logic serial;
  logic blk_end;
  logic ins_en;
  logic irq;
  logic [7:0] last_data = '0;
  logic [2:0] last_idx = '0;
  logic [31:0] r;
  int wr_cnt = 0;
  int be_cnt = 0;
  int n0 = 0;
  int cycles = 0;
  int bad_count = 0;
  int n_compared = 0;
  spbcfg_row_s rows [11] = '{
    '{OFS_CFG0, 4'hf, 32'hffff_ffff, 32'h0000_63ff},
    '{OFS_CFG1, 4'hf, 32'hffff_ffff, 32'h0000_5fff},
    '{OFS_STAT, 4'hf, 32'hffff_ffff, 32'h0000_0000},
    '{OFS_MASK, 4'hf, 32'hffff_ffff, 32'h0000_0101},
    '{OFS_CTRL, 4'hf, 32'hffff_ffff, 32'h0000_0001},
    '{8'h10, 4'hf, 32'hffff_ffff, 32'h0000_0000},
    '{OFS_CFG1, 4'h2, 32'h0000_0000, 32'h0000_00ff},
    '{OFS_CFG0, 4'hf, 32'h0000_600c, 32'h0000_600c},
    '{OFS_CFG1, 4'hf, 32'h0000_0000, 32'h0000_0000},
    '{OFS_MASK, 4'hf, 32'h0000_0000, 32'h0000_0000},
    '{OFS_CTRL, 4'hf, 32'h0000_0000, 32'h0000_0000}};

  always #2 clk = ~clk;

  spbcfg_app app (.clk(clk), .d(pd), .stb(pstb), .bsel(pbsel));

  spbcfg_top dut (.SYS_CLK(clk), .NRST(nrst), .WB_CYC_I(cyc),
    .WB_STB_I(cyc), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel),
    .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .STRM_D(pd),
    .STRM_STB(pstb), .STRM_BSEL(pbsel), .BUF_FULL(full),
    .INSERT_DONE(ins), .BUF_WR_DATA(wr_data), .BUF_WR_VALID(wr_valid),
    .BUF_WR_IDX(wr_idx), .BUF_RD_IDX(rd_idx), .BUF_MAP(map),
    .PORT_SERIAL(serial), .BLOCK_END(blk_end), .INSERT_EN(ins_en),
    .IRQ(irq));

  // Captures every byte handed to the buffers and every block end.
  always @(posedge clk) begin
    cycles++;
    if (wr_valid === 1'b1) begin
      last_data <= wr_data;
      last_idx <= wr_idx;
      wr_cnt++;
    end
    if (blk_end === 1'b1) begin
      be_cnt++;
    end
    if (cycles == 6000) begin
      bad_count++;
      conclude();
    end
  end

  task automatic conclude();
    if (bad_count == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wb(input logic [7:0] a, input logic [3:0] s,
      input logic w, input logic [31:0] dat, output logic [31:0] res);
    @(posedge clk);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= dat;
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    res = rdat;
    cyc <= 1'b0;
    we <= 1'b0;
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [31:0] dat);
    wb(a, 4'hf, 1'b1, dat, r);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    wb(a, 4'hf, 1'b0, 32'h0, r);
    chk(r, exp);
  endtask : rd

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  initial begin
    tick(20);
    nrst <= 1'b1;
    tick(1);
    chk(32'(map), 32'h0000_000c);
    rd(OFS_CFG0, 32'h0000_000c);
    chk(32'(rd_idx), 32'h2);
    foreach (rows[i]) begin
      wb(rows[i].adr, rows[i].sel, 1'b1, rows[i].wr, r);
      rd(rows[i].adr, rows[i].exp);
    end
    // Byte-wide mode with the bit order set, buffer 4 mapped alone.
    wr(OFS_CFG0, 32'h0000_6210);
    chk(32'(map), 32'h10);
    app.xfer(8'ha5, 3'h0);
    chk(32'(last_data), 32'ha5);
    chk(32'(last_idx), 32'h4);
    chk(32'(rd_idx), 32'h4);
    wr(OFS_CFG1, 32'h0000_5000);
    app.xfer(8'h3c, 3'h6);
    chk(32'(last_idx), 32'h6);
    chk(32'(rd_idx), 32'h6);
    wr(OFS_CFG1, 32'h0000_0000);
    wr(OFS_CFG0, 32'h0000_610c);
    tick(2);
    chk(32'(serial), 32'h1);
    app.send_serial(8'h55);
    chk(32'(last_data), 32'h55);
    chk(32'(last_idx), 32'h2);
    wr(OFS_CFG0, 32'h0000_630c);
    app.send_serial(8'h55);
    chk(32'(last_data), 32'haa);
    // Blocks of two bytes in mode A, one in mode B, none in mode C.
    wr(OFS_CFG1, 32'h0000_0002);
    wr(OFS_CFG0, 32'h0000_000c);
    n0 = be_cnt;
    app.xfer(8'h11, 3'h0);
    chk(32'(be_cnt - n0), 32'h0);
    app.xfer(8'h22, 3'h0);
    chk(32'(be_cnt - n0), 32'h1);
    wr(OFS_CFG1, 32'h0000_0001);
    wr(OFS_CFG0, 32'h0000_200c);
    app.xfer(8'h2d, 3'h0);
    chk(32'(be_cnt - n0), 32'h2);
    wr(OFS_CFG0, 32'h0000_600c);
    app.xfer(8'h33, 3'h0);
    app.xfer(8'h44, 3'h0);
    chk(32'(be_cnt - n0), 32'h2);
    // A byte lost to a full buffer raises the overflow flag.
    n0 = wr_cnt;
    full <= 1'b1;
    app.xfer(8'h55, 3'h0);
    full <= 1'b0;
    chk(32'(wr_cnt - n0), 32'h0);
    chk(32'(irq), 32'h0);
    wr(OFS_MASK, 32'h0000_0001);
    tick(2);
    chk(32'(irq), 32'h1);
    rd(OFS_STAT, 32'h0000_0001);
    tick(2);
    chk(32'(irq), 32'h0);
    rd(OFS_STAT, 32'h0000_0000);
    // Insertion completes, disables itself, and is enabled again.
    wr(OFS_CTRL, 32'h0000_0001);
    tick(2);
    chk(32'(ins_en), 32'h1);
    ins <= 1'b1;
    tick(1);
    ins <= 1'b0;
    tick(2);
    chk(32'(ins_en), 32'h0);
    wr(OFS_MASK, 32'h0000_0100);
    tick(2);
    chk(32'(irq), 32'h1);
    rd(OFS_STAT, 32'h0000_0100);
    wr(OFS_CTRL, 32'h0000_0001);
    tick(2);
    chk(32'(ins_en), 32'h1);
    // A reset in mid-run brings every register back to its reset value.
    nrst <= 1'b0;
    tick(2);
    nrst <= 1'b1;
    tick(1);
    chk(32'(map), 32'h0000_000c);
    chk(32'(ins_en), 32'h0);
    rd(OFS_CFG0, 32'h0000_000c);
    rd(OFS_CFG1, 32'h0000_0000);
    rd(OFS_MASK, 32'h0000_0000);
    conclude();
  end
endmodule : tb
